// File: shared/bbfc_map.svh
// bbfc_map.svh: encodings, field positions and reset values of the
// branch / breakpoint / fp-compare executor.
// assumes: included by the package user files only, definitions only.
`ifndef BBFC_MAP_SVH
`define BBFC_MAP_SVH
`define BBFC_OP_SPECIAL 6'h00
`define BBFC_OP_BNEQ 6'h05
`define BBFC_OP_BNEQ_LIKELY 6'h15
`define BBFC_OP_FPGRP 6'h11
`define BBFC_FN_BREAKPT 6'h0D
`define BBFC_FMT_SGL 5'h10
`define BBFC_FMT_DBL 5'h11
`define BBFC_FMT_PAIR 5'h16
`define BBFC_CMP_FN_HI 2'h3
`define BBFC_OPC_LSB 26
`define BBFC_SRC1_LSB 21
`define BBFC_SRC2_LSB 16
`define BBFC_FS_LSB 11
`define BBFC_CC_LSB 8
`define BBFC_FN_LSB 0
`define BBFC_CC_RST 8'h00
`define BBFC_PC_RST 32'h00000000
`endif

// File: shared/bbfc_pkg.sv
// bbfc_pkg.sv: types shared by the executor and its comparator.
// assumes: nothing beyond a SystemVerilog compiler.
package bbfc_pkg;
	typedef struct packed
	{
		logic less;
		logic equal;
		logic unord;
		logic invalid;
	} bbfc_rel_s;
	typedef enum logic [1:0]
	{
		BBFC_KIND_NONE,
		BBFC_KIND_BRANCH,
		BBFC_KIND_BREAK,
		BBFC_KIND_CMP
	} bbfc_kind_e;
	typedef struct packed
	{
		logic [31:0] target;
		logic taken;
		logic nullify;
	} bbfc_redir_s;
endpackage

// File: logic/bbfc_fcmp.sv
// bbfc_fcmp.sv: exact ieee compare of two values of one width.
// assumes: combinational; caller picks the width per format.
`timescale 1ns/100ps
module bbfc_fcmp #(
	parameter int EW = 8,
	parameter int MW = 23
)(
	input wire logic [EW+MW:0] i_a,
	input wire logic [EW+MW:0] i_b,
	input wire logic i_sig_quiet,
	output bbfc_pkg::bbfc_rel_s o_rel
);
	logic a_nan, b_nan, a_snan, b_snan, a_zero, b_zero, mag_lt, mag_eq;

	// --------------------------------------------------------------
	// classify operands
	// --------------------------------------------------------------
	assign a_nan = (&i_a[EW+MW-1:MW]) && (|i_a[MW-1:0]);
	assign b_nan = (&i_b[EW+MW-1:MW]) && (|i_b[MW-1:0]);
	assign a_snan = a_nan && !i_a[MW-1];
	assign b_snan = b_nan && !i_b[MW-1];
	assign a_zero = ~|i_a[EW+MW-1:0];
	assign b_zero = ~|i_b[EW+MW-1:0];
	assign mag_lt = i_a[EW+MW-1:0] < i_b[EW+MW-1:0];
	assign mag_eq = i_a[EW+MW-1:0] == i_b[EW+MW-1:0];

	// at most one relation holds, none when greater; nan forces unordered
	always_comb
	begin
		o_rel.unord = a_nan || b_nan;
		o_rel.equal = 1'b0;
		o_rel.less = 1'b0;
		// snan always signals, qnan only when asked
		o_rel.invalid = a_snan || b_snan ||
			(i_sig_quiet && o_rel.unord);
		if (!o_rel.unord)
		begin
			if (a_zero && b_zero)
				o_rel.equal = 1'b1;
			else if (i_a[EW+MW] != i_b[EW+MW])
				o_rel.less = i_a[EW+MW];
			else
			begin
				o_rel.equal = mag_eq;
				// negative values order by reversed magnitude
				o_rel.less = i_a[EW+MW] ? (!mag_lt && !mag_eq) : mag_lt;
			end
		end
	end
endmodule

// File: logic/bbfc_exec.sv
// bbfc_exec.sv: executes not-equal branches, breakpoint and fp compare.
// assumes: register operands arrive with the instruction in one cycle;
// the pipeline around acts on the one-cycle pulses this block gives.
`timescale 1ns/100ps
`include "bbfc_map.svh"
module bbfc_exec #(
	parameter int CC_N = 8
)(
	input wire logic i_mclk,
	input wire logic i_sys_rst,
	input wire logic i_valid,
	input wire logic [31:0] i_instr,
	input wire logic [31:0] i_pc,
	input wire logic [31:0] i_src1_val,
	input wire logic [31:0] i_src2_val,
	input wire logic [63:0] i_fp_src1_val,
	input wire logic [63:0] i_fp_src2_val,
	input wire logic i_inv_enable,
	output logic [4:0] o_src1_sel,
	output logic [4:0] o_src2_sel,
	output bbfc_pkg::bbfc_redir_s o_redir,
	output logic o_redir_valid,
	output logic o_break_trap,
	output logic o_inv_trap,
	output logic o_inv_flag_set,
	output logic [CC_N-1:0] o_cond_codes,
	output bbfc_pkg::bbfc_kind_e o_kind
);
	logic [5:0] opc;
	logic [5:0] fn;
	logic [4:0] fmt;
	logic [2:0] cc_sel;
	logic [3:0] cond;
	logic is_bne, is_branch_not_equal_likely, is_brk, is_cmp;
	logic unequal;
	logic [31:0] slot_pc, offs, tgt;
	bbfc_pkg::bbfc_rel_s rel_s, rel_d, rel_hi;
	logic res_lo, res_hi, inv_any;
	bbfc_pkg::bbfc_kind_e kind_next;

	// ------------------------------------------------------------
	// field extraction and decode
	// ------------------------------------------------------------
	// shared relation-to-result equation for both paired halves
	function automatic logic cmp_result(input logic [3:0] c,
		input bbfc_pkg::bbfc_rel_s r);
		cmp_result = (c[2] & r.less) | (c[1] & r.equal) |
			(c[0] & r.unord);
	endfunction

	assign opc = i_instr[31:`BBFC_OPC_LSB];
	assign fn = i_instr[`BBFC_FN_LSB+5:`BBFC_FN_LSB];
	assign fmt = i_instr[25:`BBFC_SRC1_LSB];
	assign cc_sel = i_instr[`BBFC_CC_LSB+2:`BBFC_CC_LSB];
	assign cond = i_instr[3:0];
	// the 20-bit code field is deliberately never looked at
	assign is_brk = i_valid && opc == `BBFC_OP_SPECIAL &&
		fn == `BBFC_FN_BREAKPT;
	assign is_bne = i_valid && opc == `BBFC_OP_BNEQ;
	assign is_branch_not_equal_likely = i_valid && opc == `BBFC_OP_BNEQ_LIKELY;
	assign is_cmp = i_valid && opc == `BBFC_OP_FPGRP &&
		fn[5:4] == `BBFC_CMP_FN_HI &&
		(fmt == `BBFC_FMT_SGL || fmt == `BBFC_FMT_DBL ||
		fmt == `BBFC_FMT_PAIR);

	// ------------------------------------------------------------
	// branch target and condition
	// ------------------------------------------------------------
	// register selects route to the general file, combinational reads
	assign o_src1_sel = i_instr[25:`BBFC_SRC1_LSB];
	assign o_src2_sel = i_instr[20:`BBFC_SRC2_LSB];
	assign unequal = i_src1_val != i_src2_val;
	assign slot_pc = i_pc + 32'h00000004;
	assign offs = {{14{i_instr[15]}}, i_instr[15:0], 2'h0};
	assign tgt = slot_pc + offs;

	// ------------------------------------------------------------
	// fp comparators: one single, one double, one for upper half
	// ------------------------------------------------------------
	bbfc_fcmp #(.EW(8), .MW(23)) u_cmp_s (
		.i_a(i_fp_src1_val[31:0]),
		.i_b(i_fp_src2_val[31:0]),
		.i_sig_quiet(cond[3]),
		.o_rel(rel_s)
	);
	bbfc_fcmp #(.EW(11), .MW(52)) u_cmp_d (
		.i_a(i_fp_src1_val),
		.i_b(i_fp_src2_val),
		.i_sig_quiet(cond[3]),
		.o_rel(rel_d)
	);
	bbfc_fcmp #(.EW(8), .MW(23)) u_cmp_hi (
		.i_a(i_fp_src1_val[63:32]),
		.i_b(i_fp_src2_val[63:32]),
		.i_sig_quiet(cond[3]),
		.o_rel(rel_hi)
	);

	// pick per format; paired halves OR their invalid events
	always_comb
	begin
		res_hi = cmp_result(cond, rel_hi);
		if (fmt == `BBFC_FMT_DBL)
		begin
			res_lo = cmp_result(cond, rel_d);
			inv_any = rel_d.invalid;
		end
		else if (fmt == `BBFC_FMT_PAIR)
		begin
			res_lo = cmp_result(cond, rel_s);
			inv_any = rel_s.invalid | rel_hi.invalid;
		end
		else
		begin
			res_lo = cmp_result(cond, rel_s);
			inv_any = rel_s.invalid;
		end
	end

	always_comb
	begin
		if (is_brk)
			kind_next = bbfc_pkg::BBFC_KIND_BREAK;
		else if (is_bne || is_branch_not_equal_likely)
			kind_next = bbfc_pkg::BBFC_KIND_BRANCH;
		else if (is_cmp)
			kind_next = bbfc_pkg::BBFC_KIND_CMP;
		else
			kind_next = bbfc_pkg::BBFC_KIND_NONE;
	end

	// ------------------------------------------------------------
	// registered outputs
	// ------------------------------------------------------------
	// redirect is posted for the slot; slot itself already fetched
	always_ff @(posedge i_mclk or posedge i_sys_rst)
	begin
		if (i_sys_rst)
		begin
			o_redir <= '0;
			o_redir_valid <= 1'b0;
		end
		else
		begin
			o_redir_valid <= is_bne || is_branch_not_equal_likely;
			o_redir.target <= tgt;
			o_redir.taken <= (is_bne || is_branch_not_equal_likely) && unequal;
			// only likely form drops the slot when falling through
			o_redir.nullify <= is_branch_not_equal_likely && !unequal;
		end
	end

	// breakpoint traps in the cycle after decode, unconditionally
	always_ff @(posedge i_mclk or posedge i_sys_rst)
	begin
		if (i_sys_rst)
			o_break_trap <= 1'b0;
		else
			o_break_trap <= is_brk;
	end

	// invalid flag pulse always; trap only when enabled
	always_ff @(posedge i_mclk or posedge i_sys_rst)
	begin
		if (i_sys_rst)
		begin
			o_inv_flag_set <= 1'b0;
			o_inv_trap <= 1'b0;
		end
		else
		begin
			o_inv_flag_set <= is_cmp && inv_any;
			o_inv_trap <= is_cmp && inv_any && i_inv_enable;
		end
	end

	// condition codes update at the edge, so the next one sees it
	always_ff @(posedge i_mclk or posedge i_sys_rst)
	begin
		if (i_sys_rst)
			o_cond_codes <= CC_N'(`BBFC_CC_RST);
		else if (is_cmp && !(inv_any && i_inv_enable))
		begin
			o_cond_codes[cc_sel] <= res_lo;
			// odd cc with paired format gets only the upper half result; the lower one is lost
			if (fmt == `BBFC_FMT_PAIR)
				o_cond_codes[cc_sel | 3'h1] <= res_hi;
		end
	end

	always_ff @(posedge i_mclk or posedge i_sys_rst)
	begin
		if (i_sys_rst)
			o_kind <= bbfc_pkg::BBFC_KIND_NONE;
		else
			o_kind <= kind_next;
	end
endmodule

// File: testbench/bbfc_exec_chk.sv
// bbfc_exec_chk.sv: port assertions for the executor.
// assumes: bound onto bbfc_exec; one clock, async active-high reset.
`timescale 1ns/100ps
`include "bbfc_map.svh"
module bbfc_exec_chk #(
	parameter int CC_N = 8
)(
	input wire logic i_mclk,
	input wire logic i_sys_rst,
	input wire logic i_valid,
	input wire logic [31:0] i_instr,
	input wire logic [31:0] i_pc,
	input wire logic [31:0] i_src1_val,
	input wire logic [31:0] i_src2_val,
	input wire logic i_inv_enable,
	input wire bbfc_pkg::bbfc_redir_s o_redir,
	input wire logic o_redir_valid,
	input wire logic o_break_trap,
	input wire logic o_inv_trap,
	input wire logic o_inv_flag_set,
	input wire logic [CC_N-1:0] o_cond_codes,
	input wire bbfc_pkg::bbfc_kind_e o_kind
);
	// ----------------------------------------
	// decode helpers
	// ----------------------------------------
	wire logic [5:0] op = i_instr[31:26];
	wire logic is_lk = op == `BBFC_OP_BNEQ_LIKELY;
	wire logic is_br = i_valid && (op == `BBFC_OP_BNEQ || is_lk);
	wire logic is_brk = i_valid && op == `BBFC_OP_SPECIAL
		&& i_instr[5:0] == `BBFC_FN_BREAKPT;
	wire logic is_cmp = i_valid && op == `BBFC_OP_FPGRP;
	// offset counts from the delay slot, not from the branch
	wire logic [31:0] tgt = i_pc + 32'h4
		+ {{14{i_instr[15]}}, i_instr[15:0], 2'h0};
	default clocking cb @(posedge i_mclk);
	endclocking
	default disable iff (i_sys_rst);
	property p_target;
		is_br |=> o_redir_valid && o_redir.target == $past(tgt);
	endproperty
	a_target: assert property (p_target)
		else $error("bad target");
	property p_taken;
		is_br |=> o_redir.taken == ($past(i_src1_val) != $past(i_src2_val));
	endproperty
	a_taken: assert property (p_taken)
		else $error("bad taken");
	// a redirect may only follow a decoded branch
	property p_redir_src;
		o_redir_valid |-> $past(is_br);
	endproperty
	a_redir_src: assert property (p_redir_src)
		else $error("stray redirect");
	property p_null;
		is_br |=> o_redir.nullify == ($past(is_lk) && !o_redir.taken);
	endproperty
	a_null: assert property (p_null)
		else $error("bad nullify");
	property p_brk;
		is_brk |=> o_break_trap && o_kind == bbfc_pkg::BBFC_KIND_BREAK;
	endproperty
	a_brk: assert property (p_brk)
		else $error("no break trap");
	property p_brk_src;
		o_break_trap |-> $past(is_brk);
	endproperty
	a_brk_src: assert property (p_brk_src)
		else $error("stray break");
	property p_trap;
		o_inv_trap |-> o_inv_flag_set && $past(i_inv_enable);
	endproperty
	a_trap: assert property (p_trap)
		else $error("bad inv trap");
	property p_nowr;
		o_inv_trap |-> $stable(o_cond_codes);
	endproperty
	a_nowr: assert property (p_nowr)
		else $error("cc written on trap");
	property p_flag;
		o_inv_flag_set |-> $past(is_cmp) && o_kind == bbfc_pkg::BBFC_KIND_CMP;
	endproperty
	a_flag: assert property (p_flag)
		else $error("stray inv flag");
	property p_quiet;
		!$past(is_cmp) |-> $stable(o_cond_codes);
	endproperty
	a_quiet: assert property (p_quiet)
		else $error("cc moved");
	c_taken: cover property (is_br ##1 o_redir.taken);
	c_null: cover property (is_br ##1 o_redir.nullify);
	c_trap: cover property (o_inv_trap);
endmodule
bind bbfc_exec bbfc_exec_chk #(.CC_N(CC_N)) i_bbfc_exec_chk (
	.i_mclk, .i_sys_rst, .i_valid, .i_instr, .i_pc, .i_src1_val,
	.i_src2_val, .i_inv_enable, .o_redir, .o_redir_valid, .o_break_trap,
	.o_inv_trap, .o_inv_flag_set, .o_cond_codes, .o_kind);

// File: testbench/bbfc_gpr_model.sv
// bbfc_gpr_model.sv: general register file read by the executor.
// assumes: read combinationally from the executor's select outputs.
`timescale 1ns/100ps
module bbfc_gpr_model
(
	input wire logic [4:0] i_sel1,
	input wire logic [4:0] i_sel2,
	output logic [31:0] o_val1,
	output logic [31:0] o_val2
);
	// regs n and n+16 hold equal values; values differ otherwise
	assign o_val1 = {8{i_sel1[3:0]}};
	assign o_val2 = {8{i_sel2[3:0]}};
endmodule

// File: testbench/bbfc_exec_tb_top.sv
// bbfc_exec_tb_top.sv: directed run of branch, breakpoint and compare.
// assumes: executor answers one edge after it takes an instruction.
`timescale 1ns/100ps
`include "bbfc_map.svh"
`define CHK(a, e) begin tests_run++; if ((a) !== (e)) begin fails++; \
	$display("[FAIL] %0t mismatch", $time); end end
module bbfc_exec_tb_top;
	logic i_mclk = 1'b0, i_sys_rst = 1'b1, i_valid = 1'b0, en = 1'b0;
	logic [31:0] i_instr = '0, i_pc = '0, v1, v2;
	logic [63:0] fa = '0, fb = '0;
	logic [4:0] s1, s2;
	bbfc_pkg::bbfc_redir_s redir;
	bbfc_pkg::bbfc_kind_e kind;
	logic rv, brk, itr, ifl;
	logic [7:0] cc, cc_exp = 8'h00;
	logic [31:0] ta [5], tb [5];
	logic [3:0] tr [5];
	int fails = 0, tests_run = 0;
	bbfc_gpr_model i_bbfc_gpr_model (.i_sel1(s1), .i_sel2(s2),
		.o_val1(v1), .o_val2(v2));
	bbfc_exec #(.CC_N(8)) i_bbfc_exec (.i_mclk, .i_sys_rst, .i_valid, .i_instr,
		.i_pc, .i_src1_val(v1), .i_src2_val(v2), .i_fp_src1_val(fa),
		.i_fp_src2_val(fb), .i_inv_enable(en), .o_src1_sel(s1), .o_src2_sel(s2),
		.o_redir(redir), .o_redir_valid(rv), .o_break_trap(brk), .o_inv_trap(itr),
		.o_inv_flag_set(ifl), .o_cond_codes(cc), .o_kind(kind));
	// ----------------------------------------
	// clock, tasks, watchdog
	// ----------------------------------------
	initial forever #20 i_mclk = ~i_mclk;
	// one instruction per call; valid drops after one edge so none repeats
	task run(input logic [31:0] ins, input logic [31:0] p,
		input logic [63:0] a, b);
		@(posedge i_mclk);
		i_valid <= 1'b1;
		i_instr <= ins;
		i_pc <= p;
		fa <= a;
		fb <= b;
		@(posedge i_mclk);
		i_valid <= 1'b0;
		#1;
	endtask
	task end_sim;
		if (fails == 0 && tests_run > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask
	initial
	begin
		#20000;
		fails++;
		end_sim;
	end
	// ----------------------------------------
	// tests
	// ----------------------------------------
	initial
	begin
		// relation bits per case: less, equal, unordered, signalling
		ta = '{32'h3F800000, 32'h00000000, 32'h3F800000,
			32'h7FC00000, 32'h7F800001};
		tb = '{32'h40000000, 32'h80000000, 32'hBF800000,
			32'h3F800000, 32'h7F800001};
		tr = '{4'h8, 4'h4, 4'h0, 4'h2, 4'h3};
		repeat (2) @(posedge i_mclk);
		i_sys_rst <= 1'b0;
		// the delay slot never holds a branch here
		for (int k = 0; k < 4; k++)
		begin
			logic [15:0] off;
			off = k[0] ? 16'h8001 : 16'h7FFF;
			run({k[1] ? `BBFC_OP_BNEQ_LIKELY : `BBFC_OP_BNEQ, 5'h01,
				k[0] ? 5'h02 : 5'h11, off}, 32'h00040000, '0, '0);
			`CHK(rv, 1'b1)
			`CHK(kind, bbfc_pkg::BBFC_KIND_BRANCH)
			// slot at 40004: 1FFFC bytes back or forward
			`CHK(redir.target, k[0] ? 32'h00020008 : 32'h00060000)
			`CHK(redir.taken, k[0])
			`CHK(redir.nullify, k[1] & ~k[0])
		end
		run({6'h00, 20'hFFFFF, `BBFC_FN_BREAKPT}, '0, '0, '0);
		`CHK({brk, kind}, {1'b1, bbfc_pkg::BBFC_KIND_BREAK})
		run({6'h00, 20'h00000, 6'h0C}, '0, '0, '0);
		`CHK({brk, kind}, {1'b0, bbfc_pkg::BBFC_KIND_NONE})
		// upper word is a nan that a single compare must not look at
		for (int c = 0; c < 16; c++)
			for (int n = 0; n < 5; n++)
			begin
				cc_exp[c[2:0]] = (c[2] & tr[n][3]) | (c[1] & tr[n][2]) |
					(c[0] & tr[n][1]);
				run({6'h11, 5'h10, 10'h044, c[2:0], 4'h3, c[3:0]}, '0,
					{32'hFFFFFFFF, ta[n]}, {32'hFFFFFFFF, tb[n]});
				`CHK(cc, cc_exp)
				`CHK({ifl, itr}, {tr[n][0] | (c[3] & tr[n][1]), 1'b0})
			end
		// low words equal, so only a true double compare sees less
		cc_exp[1] = 1'b1;
		run({6'h11, 5'h11, 10'h044, 3'h1, 8'h34}, '0,
			64'hBFF0000000000000, 64'h3FF0000000000000);
		`CHK(cc, cc_exp)
		`CHK(kind, bbfc_pkg::BBFC_KIND_CMP)
		// paired uses an even condition number
		cc_exp[3:2] = 2'h2;
		run({6'h11, 5'h16, 10'h044, 3'h2, 8'h34}, '0,
			{32'h3F800000, 32'h40000000}, {32'h40000000, 32'h3F800000});
		`CHK(cc, cc_exp)
		@(posedge i_mclk) en <= 1'b1;
		// signalling nan in the upper half only, then in the lower only
		run({6'h11, 5'h16, 10'h044, 3'h4, 8'h32}, '0,
			{32'h7F800001, 32'h3F800000}, {2{32'h3F800000}});
		`CHK({itr, ifl, cc}, {2'h3, cc_exp})
		run({6'h11, 5'h16, 10'h044, 3'h4, 8'h32}, '0,
			{32'h3F800000, 32'h7F800001}, {2{32'h3F800000}});
		`CHK({itr, ifl, cc}, {2'h3, cc_exp})
		// enabled but clean compare still writes both halves
		cc_exp[5:4] = 2'h3;
		run({6'h11, 5'h16, 10'h044, 3'h4, 8'h32}, '0,
			{2{32'h3F800000}}, {2{32'h3F800000}});
		`CHK({itr, ifl, cc}, {2'h0, cc_exp})
		end_sim;
	end
endmodule
